// ### rtl/sgc_defines.svh
// Purpose: Offsets, field positions, reset values and timing of the switch global control bank
// Assumes: 8-bit registers on the documented register port
// Notes: Included by its bare name
`ifndef SGC_DEFINES_SVH
`define SGC_DEFINES_SVH

// ============================================================
// Register offsets
`define SGC_ADDR_CTRL0 8'h02
`define SGC_ADDR_CTRL1 8'h03
`define SGC_ADDR_CTRL2 8'h04

// ============================================================
// Field positions
`define SGC_C0_PHY_EN 3
`define SGC_C0_CONF_DROP 1
`define SGC_C0_LINK_AGE 0
`define SGC_C1_PASS_ALL 7
`define SGC_C1_FRAME_2K 6
`define SGC_C1_TX_PAUSE_DIS 5
`define SGC_C1_RX_PAUSE_DIS 4
`define SGC_C1_LEN_CHECK 3
`define SGC_C1_AGE_EN 2
`define SGC_C1_FAST_AGE 1
`define SGC_C1_BACKOFF 0
`define SGC_C2_MCAST_DIS 6
`define SGC_C2_BP_CARRIER 5

// ============================================================
// Reset values before straps and writable masks
`define SGC_CTRL0_RST 8'h04
`define SGC_CTRL1_RST 8'h00
`define SGC_CTRL2_RST 8'h60
`define SGC_CTRL0_WMASK 8'h0b
`define SGC_CTRL1_WMASK 8'hff
`define SGC_CTRL2_WMASK 8'h60

// ============================================================
// Frame constants
`define SGC_PAUSE_TYPE 16'h8808
`define SGC_PAUSE_DA 48'h0180c2000001
`define SGC_LEN_TYPE_LIMIT 16'h05dc
`define SGC_MAX_2K_BYTES 12'h800
`define SGC_BASE_MAX_BYTES 1522

// ============================================================
// Timing
`define SGC_CLK_MHZ 200
`define SGC_FAST_AGE_US 800
`define SGC_NORMAL_AGE_S 300
`define SGC_US_PER_S 1000000
`define SGC_NORMAL_AGE_US (`SGC_NORMAL_AGE_S * `SGC_US_PER_S)

`endif

// ### rtl/sgc_pkg.sv
// Purpose: Types of the switch global control bank
// Assumes: Nothing beyond the defines header
// Notes: Never imported; referenced as sgc_pkg::name
package sgc_pkg;

    typedef enum logic [1:0] {AGE_OFF, AGE_NORMAL, AGE_FAST} sgc_age_state_t;

endpackage

// ### rtl/sgc_global_ctrl.sv
// Purpose: Global control registers of a five-port switch and the policy logic they steer
// Assumes: Register port on clk; strap and link pins asynchronous; frame summaries on clk
// Notes: Straps are sampled while sys_rst is high; hold reset at least three edges
`timescale 1ns/10ps
`include "sgc_defines.svh"
`default_nettype none

module sgc_global_ctrl #(
    parameter int NUM_PORTS = 5,
    parameter int US_DIV = `SGC_CLK_MHZ,
    parameter int FAST_AGE_US = `SGC_FAST_AGE_US,
    parameter int NORMAL_AGE_US = `SGC_NORMAL_AGE_US,
    parameter int BASE_MAX_BYTES = `SGC_BASE_MAX_BYTES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata_q,
    output logic reg_rvalid_q,
    input wire logic phy_enable_strap_pin,
    input wire logic aging_strap_pin,
    input wire logic pause_disable_strap_pin,
    input wire logic backoff_strap_pin,
    input wire logic [NUM_PORTS-1:0] port_link,
    input wire logic an_tx_pause,
    input wire logic an_rx_pause,
    input wire logic frm_valid,
    input wire logic [15:0] frm_type_len,
    input wire logic [47:0] frm_da,
    input wire logic frm_is_fc,
    input wire logic frm_err,
    input wire logic [15:0] frm_payload_len,
    input wire logic [11:0] frm_byte_len,
    output logic frm_done_q,
    output logic frm_drop_q,
    output logic phy_out_en_q,
    output logic tx_fc_en_q,
    output logic rx_fc_en_q,
    output logic backoff_aggr_q,
    output logic storm_mcast_q,
    output logic bp_carrier_q,
    output logic age_tick_q,
    output logic age_fast_q,
    output logic age_all_q
);

    // ============================================================
    // Parameter checks
    if (NUM_PORTS < 1 || US_DIV < 1 || US_DIV > 65535 || FAST_AGE_US < 1 || NORMAL_AGE_US <= FAST_AGE_US ||
        BASE_MAX_BYTES < 64 || BASE_MAX_BYTES > 2047)
    begin : g_bad
        $error("sgc_global_ctrl: unsupported parameter values");
    end

    function automatic logic [7:0] sgc_merge(input logic [7:0] old_v, input logic [7:0] new_v,
        input logic [7:0] mask);
        sgc_merge = (old_v & ~mask) | (new_v & mask);
    endfunction

    // ============================================================
    // Pin synchronisers
    logic [3:0] strap_s1_q, strap_s2_q;
    logic [NUM_PORTS-1:0] link_s1_q, link_s2_q, link_prev_q;

    // Not reset, so the straps settle while reset is held
    always_ff @(posedge clk)
    begin
        strap_s1_q <= {phy_enable_strap_pin, aging_strap_pin, pause_disable_strap_pin, backoff_strap_pin};
        strap_s2_q <= strap_s1_q;
        link_s1_q <= port_link;
        link_s2_q <= link_s1_q;
        // Tracks through reset too, so a fall during reset is absorbed and not seen after release
        link_prev_q <= link_s2_q;
    end

    // ============================================================
    // Register bank
    logic [7:0] ctrl0_q, ctrl0_d, ctrl1_q, ctrl1_d, ctrl2_q, ctrl2_d, rdata_d;

    always_comb
    begin
        ctrl0_d = ctrl0_q;
        ctrl1_d = ctrl1_q;
        ctrl2_d = ctrl2_q;
        rdata_d = 8'h00;
        if (sys_rst)
        begin
            ctrl0_d = `SGC_CTRL0_RST;
            ctrl0_d[`SGC_C0_PHY_EN] = strap_s2_q[3];
            ctrl1_d = `SGC_CTRL1_RST;
            ctrl1_d[`SGC_C1_AGE_EN] = strap_s2_q[2];
            ctrl1_d[`SGC_C1_TX_PAUSE_DIS] = strap_s2_q[1];
            ctrl1_d[`SGC_C1_RX_PAUSE_DIS] = strap_s2_q[1];
            ctrl1_d[`SGC_C1_BACKOFF] = strap_s2_q[0];
            ctrl2_d = `SGC_CTRL2_RST;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `SGC_ADDR_CTRL0: ctrl0_d = sgc_merge(ctrl0_q, reg_wdata, `SGC_CTRL0_WMASK);
                `SGC_ADDR_CTRL1: ctrl1_d = sgc_merge(ctrl1_q, reg_wdata, `SGC_CTRL1_WMASK);
                `SGC_ADDR_CTRL2: ctrl2_d = sgc_merge(ctrl2_q, reg_wdata, `SGC_CTRL2_WMASK);
                default: ;
            endcase
        end
        case (reg_addr)
            `SGC_ADDR_CTRL0: rdata_d = ctrl0_q;
            `SGC_ADDR_CTRL1: rdata_d = ctrl1_q;
            `SGC_ADDR_CTRL2: rdata_d = ctrl2_q;
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk)
    begin
        ctrl0_q <= ctrl0_d;
        ctrl1_q <= ctrl1_d;
        ctrl2_q <= ctrl2_d;
        reg_rdata_q <= sys_rst ? 8'h00 : (reg_rd ? rdata_d : reg_rdata_q);
        reg_rvalid_q <= !sys_rst && reg_rd;
    end

    // ============================================================
    // Static control outputs
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            phy_out_en_q <= 1'b0;
            tx_fc_en_q <= 1'b0;
            rx_fc_en_q <= 1'b0;
            backoff_aggr_q <= 1'b0;
            storm_mcast_q <= 1'b0;
            bp_carrier_q <= 1'b1;
        end
        else
        begin
            phy_out_en_q <= ctrl0_q[`SGC_C0_PHY_EN];
            tx_fc_en_q <= an_tx_pause && !ctrl1_q[`SGC_C1_TX_PAUSE_DIS];
            rx_fc_en_q <= an_rx_pause && !ctrl1_q[`SGC_C1_RX_PAUSE_DIS];
            backoff_aggr_q <= ctrl1_q[`SGC_C1_BACKOFF];
            storm_mcast_q <= !ctrl2_q[`SGC_C2_MCAST_DIS];
            bp_carrier_q <= ctrl2_q[`SGC_C2_BP_CARRIER];
        end
    end

    // ============================================================
    // Aging timer, counted in microseconds to keep the counter short
    sgc_pkg::sgc_age_state_t age_st_q, age_st_d;
    logic [15:0] div_q, div_d;
    logic [31:0] age_cnt_q, age_cnt_d, period;
    logic fast_cyc_q, fast_cyc_d, us_tick, link_drop, tick_d;

    assign link_drop = |(link_prev_q & ~link_s2_q);
    assign us_tick = (div_q == 16'(US_DIV - 1));

    always_comb
    begin
        div_d = us_tick ? 16'h0000 : div_q + 16'h0001;
        fast_cyc_d = fast_cyc_q;
        age_cnt_d = age_cnt_q;
        tick_d = 1'b0;
        if (!ctrl1_q[`SGC_C1_AGE_EN])
            age_st_d = sgc_pkg::AGE_OFF;
        else if (ctrl1_q[`SGC_C1_FAST_AGE] || fast_cyc_q)
            age_st_d = sgc_pkg::AGE_FAST;
        else
            age_st_d = sgc_pkg::AGE_NORMAL;
        period = (age_st_q == sgc_pkg::AGE_FAST) ? 32'(FAST_AGE_US) : 32'(NORMAL_AGE_US);
        case (age_st_q)
            sgc_pkg::AGE_OFF:
            begin
                age_cnt_d = 32'h0000_0000;
                fast_cyc_d = 1'b0;
            end
            sgc_pkg::AGE_NORMAL, sgc_pkg::AGE_FAST:
            begin
                if (us_tick)
                begin
                    if (age_cnt_q >= period - 32'h0000_0001)
                    begin
                        age_cnt_d = 32'h0000_0000;
                        tick_d = 1'b1;
                        fast_cyc_d = 1'b0;
                    end
                    else
                        age_cnt_d = age_cnt_q + 32'h0000_0001;
                end
            end
            default: age_cnt_d = 32'h0000_0000;
        endcase
        // A long normal count carried into the fast period would overrun it
        if (age_st_d == sgc_pkg::AGE_FAST && age_st_q != sgc_pkg::AGE_FAST)
            age_cnt_d = 32'h0000_0000;
        // A link loss in the closing cycle still earns its fast cycle
        if (link_drop && ctrl0_q[`SGC_C0_LINK_AGE] && ctrl1_q[`SGC_C1_AGE_EN])
        begin
            fast_cyc_d = 1'b1;
            if (!fast_cyc_q)
                age_cnt_d = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            div_q <= 16'h0000;
            age_st_q <= sgc_pkg::AGE_OFF;
            age_cnt_q <= 32'h0000_0000;
            fast_cyc_q <= 1'b0;
            age_tick_q <= 1'b0;
            age_fast_q <= 1'b0;
            age_all_q <= 1'b0;
        end
        else
        begin
            div_q <= div_d;
            age_st_q <= age_st_d;
            age_cnt_q <= age_cnt_d;
            fast_cyc_q <= fast_cyc_d;
            age_tick_q <= tick_d;
            age_fast_q <= (age_st_d == sgc_pkg::AGE_FAST);
            age_all_q <= link_drop;
        end
    end

    // ============================================================
    // Frame acceptance
    logic is_pause, fc_drop, len_bad, size_bad, drop_d;

    always_comb
    begin
        is_pause = (frm_type_len == `SGC_PAUSE_TYPE) || (frm_da == `SGC_PAUSE_DA);
        fc_drop = ctrl0_q[`SGC_C0_CONF_DROP] ? is_pause : frm_is_fc;
        len_bad = ctrl1_q[`SGC_C1_LEN_CHECK] && (frm_type_len < `SGC_LEN_TYPE_LIMIT) &&
            (frm_type_len != frm_payload_len);
        size_bad = ctrl1_q[`SGC_C1_FRAME_2K] ? (frm_byte_len > `SGC_MAX_2K_BYTES) :
            (frm_byte_len > 12'(BASE_MAX_BYTES));
        drop_d = !ctrl1_q[`SGC_C1_PASS_ALL] && (fc_drop || len_bad || size_bad || frm_err);
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            frm_done_q <= 1'b0;
            frm_drop_q <= 1'b0;
        end
        else
        begin
            frm_done_q <= frm_valid;
            frm_drop_q <= frm_valid ? drop_d : frm_drop_q;
        end
    end

    // ============================================================
    // Checks
    phy_tristate_a: assert property (@(posedge clk) disable iff (sys_rst)
        reg_wr && reg_addr == `SGC_ADDR_CTRL0 && !reg_wdata[`SGC_C0_PHY_EN] |=> ##1 !phy_out_en_q)
        else $error("phy outputs not isolated");
    conf_drop_a: assert property (@(posedge clk) disable iff (sys_rst)
        frm_valid && !ctrl1_q[`SGC_C1_PASS_ALL] && ctrl0_q[`SGC_C0_CONF_DROP] && frm_da == `SGC_PAUSE_DA
        |=> frm_done_q && frm_drop_q)
        else $error("reserved address frame kept");
    fc_drop_a: assert property (@(posedge clk) disable iff (sys_rst)
        frm_valid && !ctrl1_q[`SGC_C1_PASS_ALL] && !ctrl0_q[`SGC_C0_CONF_DROP] && frm_is_fc |=> frm_drop_q)
        else $error("flow control frame kept");
    fast_bound_a: assert property (@(posedge clk) disable iff (sys_rst)
        age_st_q == sgc_pkg::AGE_FAST |-> age_cnt_q < 32'(FAST_AGE_US))
        else $error("fast age cycle overran");
    unplug_flush_a: assert property (@(posedge clk) disable iff (sys_rst)
        (|($past(link_s2_q) & ~link_s2_q)) |-> ##1 age_all_q)
        else $error("unplug did not flush table");
    pass_all_a: assert property (@(posedge clk) disable iff (sys_rst)
        frm_valid && ctrl1_q[`SGC_C1_PASS_ALL] |=> frm_done_q && !frm_drop_q)
        else $error("frame dropped in pass-all");
    size_limit_a: assert property (@(posedge clk) disable iff (sys_rst)
        frm_valid && !ctrl1_q[`SGC_C1_PASS_ALL] && frm_byte_len > `SGC_MAX_2K_BYTES |=> frm_drop_q)
        else $error("oversize frame kept");
    tx_pause_a: assert property (@(posedge clk) disable iff (sys_rst)
        ctrl1_q[`SGC_C1_TX_PAUSE_DIS] || !an_tx_pause |=> !tx_fc_en_q)
        else $error("tx flow control on while disabled");
    rx_pause_a: assert property (@(posedge clk) disable iff (sys_rst)
        !ctrl1_q[`SGC_C1_RX_PAUSE_DIS] && an_rx_pause |=> rx_fc_en_q)
        else $error("rx flow control not following negotiation");
    len_check_a: assert property (@(posedge clk) disable iff (sys_rst)
        frm_valid && !ctrl1_q[`SGC_C1_PASS_ALL] && ctrl1_q[`SGC_C1_LEN_CHECK] &&
        frm_type_len < `SGC_LEN_TYPE_LIMIT && frm_type_len != frm_payload_len |=> frm_drop_q)
        else $error("length mismatch frame kept");
    aging_off_a: assert property (@(posedge clk) disable iff (sys_rst)
        !ctrl1_q[`SGC_C1_AGE_EN] ##1 !ctrl1_q[`SGC_C1_AGE_EN] |=> !age_tick_q && !age_fast_q)
        else $error("aging while disabled");

endmodule

`default_nettype wire

// ### testbench/sgc_global_ctrl_tb.sv
// Purpose: Self-checking bench of the switch global control bank
// Assumes: US_DIV 2, FAST_AGE_US 4, NORMAL_AGE_US 16 keep aging runs short
// Notes: A bench model of the three registers predicts every read, level and verdict
`timescale 1ns/10ps
`include "sgc_defines.svh"
`default_nettype none

module sgc_global_ctrl_tb;
    // ============================================================
    // Signals and model state
    logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_q, m0, m1, m2;
    logic phy_enable_strap_pin = 1'b1, aging_strap_pin = 1'b1;
    logic pause_disable_strap_pin = 1'b0, backoff_strap_pin = 1'b0;
    logic [4:0] port_link = 5'h1f;
    logic an_tx_pause = 1'b1, an_rx_pause = 1'b1, frm_valid = 1'b0, frm_is_fc = 1'b0, frm_err = 1'b0;
    logic [15:0] frm_type_len = 16'h0000, frm_payload_len = 16'h0000;
    logic [47:0] frm_da = 48'h0;
    logic [11:0] frm_byte_len = 12'h000;
    logic reg_rvalid_q, frm_done_q, frm_drop_q, phy_out_en_q, tx_fc_en_q, rx_fc_en_q;
    logic backoff_aggr_q, storm_mcast_q, bp_carrier_q, age_tick_q, age_fast_q, age_all_q;
    int num_errors = 0, compares = 0, cyc = 0, seed = 32'h2e4f, n, first;
    logic seen;

    sgc_global_ctrl #(.NUM_PORTS(5), .US_DIV(2), .FAST_AGE_US(4), .NORMAL_AGE_US(16), .BASE_MAX_BYTES(1522)) dut (
        .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
        .phy_enable_strap_pin(phy_enable_strap_pin), .aging_strap_pin(aging_strap_pin),
        .pause_disable_strap_pin(pause_disable_strap_pin), .backoff_strap_pin(backoff_strap_pin),
        .port_link(port_link), .an_tx_pause(an_tx_pause), .an_rx_pause(an_rx_pause),
        .frm_valid(frm_valid), .frm_type_len(frm_type_len), .frm_da(frm_da), .frm_is_fc(frm_is_fc),
        .frm_err(frm_err), .frm_payload_len(frm_payload_len), .frm_byte_len(frm_byte_len),
        .frm_done_q(frm_done_q), .frm_drop_q(frm_drop_q), .phy_out_en_q(phy_out_en_q),
        .tx_fc_en_q(tx_fc_en_q), .rx_fc_en_q(rx_fc_en_q), .backoff_aggr_q(backoff_aggr_q),
        .storm_mcast_q(storm_mcast_q), .bp_carrier_q(bp_carrier_q), .age_tick_q(age_tick_q),
        .age_fast_q(age_fast_q), .age_all_q(age_all_q));

    // ============================================================
    // Clock and hang guard
    initial
    begin
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            num_errors++;
            tally_and_finish();
        end
    end

    // ============================================================
    // Compares and bus cycles
    task automatic chk_bit(input string nm, input logic e, input logic g);
        compares++;
        if (g !== e)
        begin
            num_errors++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk) #1;
        reg_wr = 1'b0;
        if (a == `SGC_ADDR_CTRL0) m0 = (m0 & 8'hf4) | (d & 8'h0b);
        if (a == `SGC_ADDR_CTRL1) m1 = d;
        if (a == `SGC_ADDR_CTRL2) m2 = d & 8'h60;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk) #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk) #1;
        reg_rd = 1'b0;
        chk_bit("reg_rvalid_q", 1'b1, reg_rvalid_q);
        chk_byte("reg_rdata_q", (a == 8'h02) ? m0 : (a == 8'h03) ? m1 : (a == 8'h04) ? m2 : 8'h00, reg_rdata_q);
    endtask

    // Static levels settle one edge after the register write
    task automatic chk_static();
        @(posedge clk) #1;
        chk_bit("phy_out_en_q", m0[3], phy_out_en_q);
        chk_bit("tx_fc_en_q", an_tx_pause & ~m1[5], tx_fc_en_q);
        chk_bit("rx_fc_en_q", an_rx_pause & ~m1[4], rx_fc_en_q);
        chk_bit("backoff_aggr_q", m1[0], backoff_aggr_q);
        chk_bit("storm_mcast_q", ~m2[6], storm_mcast_q);
        chk_bit("bp_carrier_q", m2[5], bp_carrier_q);
    endtask

    task automatic do_reset();
        logic [3:0] s;
        s = 4'($random(seed));
        {phy_enable_strap_pin, aging_strap_pin, pause_disable_strap_pin, backoff_strap_pin} = s;
        sys_rst = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        m0 = 8'h04 | {4'h0, s[3], 3'h0};
        m1 = {2'h0, s[1], s[1], 1'b0, s[2], 1'b0, s[0]};
        m2 = 8'h60;
        // Straps move after release; the loaded defaults must not follow them
        {phy_enable_strap_pin, aging_strap_pin, pause_disable_strap_pin, backoff_strap_pin} = ~s;
        chk_static();
        for (int a = 2; a < 5; a++) rd(8'(a));
    endtask

    task automatic frame();
        logic [15:0] t;
        logic [7:0] r;
        logic fc, lb, sb;
        t = 16'($random(seed));
        r = 8'($random(seed));
        if (r[7:6] == 2'h0) t = `SGC_PAUSE_TYPE;
        if (r[7:6] == 2'h1) t = t & 16'h07ff;
        if (r[7:6] == 2'h2) t = 16'd1500;
        @(posedge clk) #1;
        frm_type_len = t;
        frm_da = r[5] ? `SGC_PAUSE_DA : {16'h0180, 32'($random(seed))};
        frm_payload_len = r[1] ? t : t ^ 16'h0001;
        frm_is_fc = r[2];
        frm_err = (r[4:3] == 2'h0);
        frm_byte_len = 12'd1500 + (12'($random(seed)) & 12'h3ff);
        frm_valid = 1'b1;
        fc = m0[1] ? (t == 16'h8808 || frm_da == 48'h0180c2000001) : frm_is_fc;
        lb = m1[3] && t < 16'd1500 && t != frm_payload_len;
        sb = frm_byte_len > (m1[6] ? 12'd2048 : 12'd1522);
        @(posedge clk) #1;
        frm_valid = 1'b0;
        chk_bit("frm_done_q", 1'b1, frm_done_q);
        chk_bit("frm_drop_q", ~m1[7] & (fc | lb | sb | frm_err), frm_drop_q);
    endtask

    // Cycles to the next age tick, then cycles between it and the following one
    task automatic tick_gap(output int wait1, output int gap);
        wait1 = 0;
        gap = 0;
        while (age_tick_q !== 1'b1 && wait1 < 100)
        begin
            @(posedge clk) #1;
            wait1++;
        end
        do
        begin
            @(posedge clk) #1;
            gap++;
        end while (age_tick_q !== 1'b1 && gap < 100);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ============================================================
    // Main sequence
    initial
    begin
        for (int i = 0; i < 3; i++) do_reset();
        $display("test reset defaults done");
        for (int i = 0; i < 8; i++)
        begin
            {an_tx_pause, an_rx_pause} = 2'($random(seed));
            for (int a = 2; a < 5; a++) wr(8'(a), 8'($random(seed)));
            wr(8'h05 + 8'(i), 8'hff);
            for (int a = 2; a < 6; a++) rd(8'(a));
            chk_static();
        end
        $display("test register access done");
        for (int i = 0; i < 96; i++)
        begin
            if (i % 12 == 0) wr(`SGC_ADDR_CTRL0, 8'($random(seed)));
            if (i % 12 == 0) wr(`SGC_ADDR_CTRL1, 8'($random(seed)) & 8'hf9);
            frame();
        end
        $display("test frame policy done");
        wr(`SGC_ADDR_CTRL1, 8'h06);
        tick_gap(first, n);
        chk_byte("fast_gap", 8'd8, 8'(n));
        wr(`SGC_ADDR_CTRL1, 8'h04);
        tick_gap(first, n);
        tick_gap(first, n);
        chk_byte("normal_gap", 8'd32, 8'(n));
        wr(`SGC_ADDR_CTRL1, 8'h00);
        seen = 1'b0;
        // One tick may still land in the cycle the disable takes effect
        @(posedge clk);
        repeat (40)
        begin
            @(posedge clk) #1;
            seen = seen | age_tick_q;
        end
        chk_bit("age_tick_off", 1'b0, seen);
        $display("test aging periods done");
        for (int lc = 0; lc < 2; lc++)
        begin
            wr(`SGC_ADDR_CTRL0, 8'h08 | 8'(lc));
            wr(`SGC_ADDR_CTRL1, 8'h04);
            port_link = 5'h1b;
            n = 0;
            while (age_all_q !== 1'b1 && n < 6)
            begin
                @(posedge clk) #1;
                n++;
            end
            chk_bit("age_all_q", 1'b1, age_all_q);
            @(posedge clk) #1;
            chk_bit("age_fast_q", lc[0], age_fast_q);
            tick_gap(first, n);
            if (lc == 1) chk_bit("fast_first", 1'b1, first <= 10);
            chk_byte("after_gap", 8'd32, 8'(n));
            chk_bit("age_fast_end", 1'b0, age_fast_q);
            port_link = 5'h1f;
            repeat (4) @(posedge clk);
            #1;
        end
        $display("test link change aging done");
        tally_and_finish();
    end
endmodule

`default_nettype wire
